/* rtl/gksp_params.svh */
// Register indices, field positions and timing counts of the GPIO block
`ifndef GKSP_PARAMS_SVH
`define GKSP_PARAMS_SVH

// Register indices; byte address is four times the index
`define GKSP_IDX_P1_ALT 10'h0D5
`define GKSP_IDX_P2_ALT 10'h0D5
`define GKSP_IDX_P0_DATA 10'h0D8
`define GKSP_IDX_P1_DATA 10'h0D9
`define GKSP_IDX_P2_DATA 10'h0DA
`define GKSP_IDX_P3_DATA 10'h0DB
`define GKSP_IDX_PORT0_DIRECTION 10'h240
`define GKSP_IDX_PORT0_PIN_CONFIG 10'h241
`define GKSP_IDX_PORT1_DIRECTION 10'h244
`define GKSP_IDX_PORT1_PIN_CONFIG 10'h245
`define GKSP_IDX_PORT2_DIRECTION 10'h248
`define GKSP_IDX_PORT2_PIN_CONFIG 10'h249
`define GKSP_IDX_PORT3_NIBBLE_DIRECTION 10'h24C
`define GKSP_IDX_LCD_CTL 10'h250
`define GKSP_IDX_KS_CTL 10'h252
`define GKSP_IDX_KS_COM 10'h253
`define GKSP_IDX_KS_LATCH 10'h254
`define GKSP_IDX_IRQ_EN 10'h260
`define GKSP_IDX_IRQ_ST 10'h261
`define GKSP_IDX_HALT_RELEASE_ENABLE 10'h262
`define GKSP_IDX_TMCLK 10'h263

// Field positions
`define GKSP_BIT_SEG_BLANK 0
`define GKSP_BIT_KS_CLEAR 1
`define GKSP_BIT_LCD_FOUR 6
`define GKSP_BIT_LCD_ON 7
`define GKSP_BIT_P0_EVENT 2
`define GKSP_CFG_PU 0
`define GKSP_CFG_OD 1
`define GKSP_CFG_WEAK 2
`define GKSP_CFG_KS 3
`define GKSP_CFG_HI 4

// Reset value of every control register
`define GKSP_RST_BYTE 8'h00

// Timer clock select codes
`define GKSP_TMSEL_PIN 2'b11
`define GKSP_TMSEL_XTAL 2'b10

// Pull-up window at the tail of each common period
`define GKSP_CLK_PERIOD_NS 25
`define GKSP_KS_PULL_US 30
`define GKSP_KS_PULL_CYC ((`GKSP_KS_PULL_US * 1000) / `GKSP_CLK_PERIOD_NS)

`endif

/* rtl/gksp_pkg.sv */
// Types shared by the GPIO and key strobe block
package gksp_pkg;

  typedef struct packed {
    logic [7:0] p3;
    logic [1:0] p2;
    logic [1:0] p1;
    logic [5:0] p0;
  } gksp_pads_t;

  typedef enum logic [1:0] {
    GKSP_BUS_IDLE = 2'b00,
    GKSP_BUS_RD_WAIT = 2'b01,
    GKSP_BUS_RD_DONE = 2'b11,
    GKSP_BUS_WRITE = 2'b10
  } gksp_bus_t;

  typedef struct packed {
    gksp_bus_t bus;
    logic [9:0] idx;
    logic [31:0] rdata;
    logic [5:0] p0_data;
    logic [5:0] port0_direction;
    logic [7:0] port0_pin_config;
    logic [1:0] p1_data;
    logic [1:0] port1_direction;
    logic [3:0] port1_pin_config;
    logic [1:0] p1_alt;
    logic [1:0] p2_data;
    logic [1:0] port2_direction;
    logic [3:0] port2_pin_config;
    logic [7:0] p3_data;
    logic [1:0] port3_nibble_direction;
    logic seg_blank;
    logic lcd_on;
    logic lcd_four;
    logic [7:0] latch;
    logic [2:0] com_idx;
    logic armed;
    logic irq_en;
    logic irq_st;
    logic halt_release_enable;
    logic [3:0] tmsel;
    gksp_pads_t pad_q;
    logic [1:0] p0_prev;
  } gksp_state_t;

endpackage

/* rtl/gksp_top.sv */
// GPIO ports 0..3 with key strobe scanner behind an AHB-Lite slave
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
`include "gksp_params.svh"

module gksp_top (
  input wire logic clk, // System clock, 40 MHz
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data
  input wire gksp_pkg::gksp_pads_t pad_in, // Pad levels
  output gksp_pkg::gksp_pads_t pad_out, // Pad drive values
  output gksp_pkg::gksp_pads_t pad_oe, // Pad drive enables
  output gksp_pkg::gksp_pads_t pad_pullup, // Pull-up switched on
  output gksp_pkg::gksp_pads_t pad_weak, // Weak pull-up chosen
  input wire logic [2:0] lcd_com_index, // Active common number
  input wire logic lcd_com_low, // Common in its low-active period
  input wire logic [15:0] lcd_com_left, // Cycles left in that period
  input wire logic [31:0] seg_data, // Display RAM segment bits
  output logic [31:0] seg_out, // Segment outputs
  output logic lcd_on, // LCD switched on
  output logic lcd_four_com, // Four-common mode
  input wire logic [1:0] port3_enable, // Port 3 nibble enables
  input wire logic first_timer_carrier, // Carrier of first timer
  input wire logic second_timer_carrier, // Carrier of second timer
  input wire logic slow_crystal_clock, // Slow crystal clock level
  output logic first_timer_clk_in, // External clock, first timer
  output logic second_timer_clk_in, // Clock chosen for second timer
  output logic port0_irq, // Port 0 interrupt and stop wake
  output logic halt_release // Port 0 halt release request
);
  import gksp_pkg::*;

  localparam logic [15:0] KS_PULL_CYC = 16'(`GKSP_KS_PULL_CYC);

  gksp_state_t st;
  gksp_state_t next_st;

  logic addr_ok;
  logic take;
  logic window;
  logic scan_active;
  logic [7:0] ks_pins;
  logic [7:0] low_hits;
  logic capture;
  logic clear_req;
  logic p0_edge;
  logic [31:0] read_val;

  // Pull-up for one pin group; strobe pins pull only in the window while the LCD is on
  function automatic logic pull_on(input logic pu, input logic ks,
                                   input logic dir, input logic win);
    pull_on = pu & ~dir & (~ks | ~st.lcd_on | win);
  endfunction

  // Addresses above the low 4 KB decode to an unused index; alignment is not checked
  assign addr_ok = (haddr[31:12] == 20'h00000);
  assign take = hsel & hready & htrans[1];

  // Pull-up window covers the tail of each common's low-active period
  assign window = lcd_com_low & (lcd_com_left <= KS_PULL_CYC);
  assign scan_active = (st.port0_pin_config[`GKSP_CFG_KS] |
                        st.port0_pin_config[`GKSP_CFG_HI + `GKSP_CFG_KS] |
                        st.port1_pin_config[`GKSP_CFG_KS]) & st.lcd_on;

  // Strobe pins map onto the latch as port 1 above port 0
  assign ks_pins = {{2{st.port1_pin_config[`GKSP_CFG_KS]}},
                    {2{st.port0_pin_config[`GKSP_CFG_HI + `GKSP_CFG_KS]}},
                    {4{st.port0_pin_config[`GKSP_CFG_KS]}}};
  assign low_hits = ks_pins & ~{st.port1_direction, st.port0_direction} &
                    ~{st.pad_q.p1, st.pad_q.p0};
  // Sampling only inside the window sees keys with the pull-up applied
  assign capture = scan_active & window & st.armed & (|low_hits);
  assign clear_req = (st.bus == GKSP_BUS_WRITE) &&
                     (st.idx == `GKSP_IDX_KS_CTL) &&
                     hwdata[`GKSP_BIT_KS_CLEAR];

  // Either edge on an input pin 0.0 or 0.4 is a port 0 event
  assign p0_edge = |((st.p0_prev ^ {st.pad_q.p0[4], st.pad_q.p0[0]}) &
                     ~{st.port0_direction[4], st.port0_direction[0]});

  // Read mux; output pins read one on ports 0-2, zero on port 3
  always_comb begin
    read_val = 32'h00000000;
    unique case (st.idx)
      `GKSP_IDX_P1_ALT: read_val[1:0] = st.p1_alt;
      `GKSP_IDX_P0_DATA: read_val[5:0] = st.port0_direction | st.pad_q.p0;
      `GKSP_IDX_P1_DATA: read_val[1:0] = st.port1_direction | st.pad_q.p1;
      `GKSP_IDX_P2_DATA: read_val[1:0] = st.port2_direction | st.pad_q.p2;
      `GKSP_IDX_P3_DATA: read_val[7:0] =
        ~{{4{st.port3_nibble_direction[1]}}, {4{st.port3_nibble_direction[0]}}} & st.pad_q.p3;
      `GKSP_IDX_PORT0_DIRECTION: read_val[5:0] = st.port0_direction;
      `GKSP_IDX_PORT0_PIN_CONFIG: read_val[7:0] = st.port0_pin_config;
      `GKSP_IDX_PORT1_DIRECTION: read_val[1:0] = st.port1_direction;
      `GKSP_IDX_PORT1_PIN_CONFIG: read_val[3:0] = st.port1_pin_config;
      `GKSP_IDX_PORT2_DIRECTION: read_val[1:0] = st.port2_direction;
      `GKSP_IDX_PORT2_PIN_CONFIG: read_val[3:0] = st.port2_pin_config;
      `GKSP_IDX_PORT3_NIBBLE_DIRECTION: read_val[1:0] = st.port3_nibble_direction;
      `GKSP_IDX_LCD_CTL: begin
        read_val[`GKSP_BIT_LCD_ON] = st.lcd_on;
        read_val[`GKSP_BIT_LCD_FOUR] = st.lcd_four;
      end
      `GKSP_IDX_KS_COM: read_val[2:0] = st.com_idx;
      `GKSP_IDX_KS_LATCH: read_val[7:0] = st.latch;
      `GKSP_IDX_IRQ_EN: read_val[`GKSP_BIT_P0_EVENT] = st.irq_en;
      `GKSP_IDX_IRQ_ST: read_val[`GKSP_BIT_P0_EVENT] = st.irq_st;
      `GKSP_IDX_HALT_RELEASE_ENABLE: read_val[`GKSP_BIT_P0_EVENT] = st.halt_release_enable;
      `GKSP_IDX_TMCLK: read_val[3:0] = st.tmsel;
      default: read_val = 32'h00000000;
    endcase
  end

  // Next state: bus sequencing, register writes, pad sampling, scanner
  always_comb begin
    next_st = st;
    next_st.pad_q = pad_in;
    next_st.p0_prev = {st.pad_q.p0[4], st.pad_q.p0[0]};
    // Reads wait one cycle so a write just before them is visible
    unique case (st.bus)
      GKSP_BUS_RD_WAIT: begin
        next_st.rdata = read_val;
        next_st.bus = GKSP_BUS_RD_DONE;
      end
      GKSP_BUS_IDLE, GKSP_BUS_RD_DONE, GKSP_BUS_WRITE: begin
        next_st.bus = GKSP_BUS_IDLE;
      end
    endcase
    if (st.bus != GKSP_BUS_RD_WAIT && take) begin
      next_st.idx = addr_ok ? haddr[11:2] : 10'h3FF;
      next_st.bus = hwrite ? GKSP_BUS_WRITE : GKSP_BUS_RD_WAIT;
    end
    // Data phase of a write; low byte lanes carry all fields
    if (st.bus == GKSP_BUS_WRITE) begin
      unique case (st.idx)
        `GKSP_IDX_P1_ALT: next_st.p1_alt = hwdata[1:0];
        `GKSP_IDX_P0_DATA: next_st.p0_data = hwdata[5:0];
        `GKSP_IDX_P1_DATA: next_st.p1_data = hwdata[1:0];
        `GKSP_IDX_P2_DATA: next_st.p2_data = hwdata[1:0];
        `GKSP_IDX_P3_DATA: next_st.p3_data = hwdata[7:0];
        `GKSP_IDX_PORT0_DIRECTION: next_st.port0_direction = hwdata[5:0];
        `GKSP_IDX_PORT0_PIN_CONFIG: next_st.port0_pin_config = hwdata[7:0];
        `GKSP_IDX_PORT1_DIRECTION: next_st.port1_direction = hwdata[1:0];
        `GKSP_IDX_PORT1_PIN_CONFIG: next_st.port1_pin_config = hwdata[3:0];
        `GKSP_IDX_PORT2_DIRECTION: next_st.port2_direction = hwdata[1:0];
        `GKSP_IDX_PORT2_PIN_CONFIG: next_st.port2_pin_config = hwdata[3:0];
        `GKSP_IDX_PORT3_NIBBLE_DIRECTION: next_st.port3_nibble_direction = hwdata[1:0];
        `GKSP_IDX_LCD_CTL: begin
          next_st.lcd_on = hwdata[`GKSP_BIT_LCD_ON];
          next_st.lcd_four = hwdata[`GKSP_BIT_LCD_FOUR];
        end
        `GKSP_IDX_KS_CTL: next_st.seg_blank = hwdata[`GKSP_BIT_SEG_BLANK];
        `GKSP_IDX_IRQ_EN: next_st.irq_en = hwdata[`GKSP_BIT_P0_EVENT];
        `GKSP_IDX_IRQ_ST: begin
          if (hwdata[`GKSP_BIT_P0_EVENT]) begin
            next_st.irq_st = 1'b0;
          end
        end
        `GKSP_IDX_HALT_RELEASE_ENABLE: next_st.halt_release_enable = hwdata[`GKSP_BIT_P0_EVENT];
        `GKSP_IDX_TMCLK: next_st.tmsel = hwdata[3:0];
        default: next_st.seg_blank = st.seg_blank;
      endcase
    end
    // A new event beats a clear written in the same cycle
    if (p0_edge) begin
      next_st.irq_st = 1'b1;
    end
    // Strobe clear empties the latch and re-arms; a key in the same
    // cycle is caught only if the scanner was already armed
    if (clear_req) begin
      next_st.latch = 8'h00;
      next_st.armed = 1'b1;
    end
    if (capture) begin
      next_st.latch = low_hits;
      next_st.com_idx = lcd_com_index;
      next_st.armed = 1'b0;
    end
  end

  // State register; everything resets to zero except the scanner arm
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.armed <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Bus answers; only reads ever insert a wait state
  assign hreadyout = (st.bus != GKSP_BUS_RD_WAIT);
  assign hresp = 1'b0;
  assign hrdata = st.rdata;

  // Segment outputs blank to zero on request
  assign seg_out = st.seg_blank ? 32'h00000000 : seg_data;
  assign lcd_on = st.lcd_on;
  assign lcd_four_com = st.lcd_four;

  // Port 0 and 1 drivers; open-drain drives only a low
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_p0
      localparam int GRP = (gi < 4) ? 0 : `GKSP_CFG_HI;
      assign pad_out.p0[gi] = st.p0_data[gi] &
                              ~st.port0_pin_config[GRP + `GKSP_CFG_OD];
      assign pad_oe.p0[gi] = st.port0_direction[gi] &
        (~st.port0_pin_config[GRP + `GKSP_CFG_OD] | ~st.p0_data[gi]);
      assign pad_pullup.p0[gi] = pull_on(st.port0_pin_config[GRP + `GKSP_CFG_PU],
        st.port0_pin_config[GRP + `GKSP_CFG_KS], st.port0_direction[gi], window);
      assign pad_weak.p0[gi] = st.port0_pin_config[GRP + `GKSP_CFG_WEAK];
    end
    for (gi = 0; gi < 2; gi++) begin : g_p12
      logic val1;
      // Alternate select swaps the data bit for a timer carrier
      assign val1 = st.p1_alt[gi] ?
        (gi == 0 ? first_timer_carrier : second_timer_carrier) :
        st.p1_data[gi];
      assign pad_out.p1[gi] = val1 & ~st.port1_pin_config[`GKSP_CFG_OD];
      assign pad_oe.p1[gi] = st.port1_direction[gi] &
        (~st.port1_pin_config[`GKSP_CFG_OD] | ~val1);
      assign pad_pullup.p1[gi] = pull_on(st.port1_pin_config[`GKSP_CFG_PU],
        st.port1_pin_config[`GKSP_CFG_KS], st.port1_direction[gi], window);
      assign pad_weak.p1[gi] = st.port1_pin_config[`GKSP_CFG_WEAK];
      // Port 2 ignores its reserved alternate bits
      assign pad_out.p2[gi] = st.p2_data[gi] & ~st.port2_pin_config[2 + gi];
      assign pad_oe.p2[gi] = st.port2_direction[gi] &
        (~st.port2_pin_config[2 + gi] | ~st.p2_data[gi]);
      assign pad_pullup.p2[gi] = st.port2_pin_config[gi] & ~st.port2_direction[gi];
      assign pad_weak.p2[gi] = 1'b0;
    end
    // Port 3 shares pads with segments 31 down to 24
    for (gi = 0; gi < 8; gi++) begin : g_p3
      assign pad_out.p3[gi] = port3_enable[gi / 4] ? st.p3_data[gi] :
                              seg_out[31 - gi];
      assign pad_oe.p3[gi] = port3_enable[gi / 4] ? st.port3_nibble_direction[gi / 4] :
                             1'b1;
      assign pad_pullup.p3[gi] = 1'b0;
      assign pad_weak.p3[gi] = 1'b0;
    end
  endgenerate

  // First timer clock from registered pad 0.4; second from pad 0.5 or the slow crystal clock
  assign first_timer_clk_in = st.pad_q.p0[4];
  always_comb begin
    second_timer_clk_in = 1'b0;
    if (st.tmsel[3:2] == `GKSP_TMSEL_PIN) begin
      second_timer_clk_in = st.pad_q.p0[5];
    end else if (st.tmsel[3:2] == `GKSP_TMSEL_XTAL) begin
      second_timer_clk_in = slow_crystal_clock;
    end
  end

  // Port 0 event requests, gated by their enables
  assign port0_irq = st.irq_st & st.irq_en;
  assign halt_release = st.irq_st & st.halt_release_enable;

  sequence s_rd_addr;
    take && !hwrite && st.bus != GKSP_BUS_RD_WAIT;
  endsequence
  sequence s_rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_rd_wait_state: assert property (s_rd_addr |=> s_rd_answer)
    else $error("read answer not after one wait state");
  a_p0_cmos_drive: assert property (
    st.port0_direction[1] && !st.port0_pin_config[1] |->
    pad_oe.p0[1] && pad_out.p0[1] == st.p0_data[1])
    else $error("port 0 output pin not driving its data");
  a_pull_out_off: assert property (
    ((pad_pullup.p0 & st.port0_direction) | (pad_pullup.p1 & st.port1_direction)) == 0)
    else $error("pull-up on while pin is output");
  a_event_sets: assert property (
    p0_edge && !capture |=>
    st.irq_st ##1 (st.irq_st || $past(st.bus == GKSP_BUS_WRITE)))
    else $error("port 0 edge did not set event");
  a_latch_holds: assert property (
    !st.armed && !clear_req |=>
    $stable(st.latch) && $stable(st.com_idx))
    else $error("key latch changed while held");
  a_clear_rearm: assert property (
    clear_req && !capture |=>
    st.latch == 8'h00 && st.armed)
    else $error("strobe clear did not empty latch");
  a_scan_gate: assert property (
    capture |-> st.lcd_on && window &&
    (st.port0_pin_config[3] || st.port0_pin_config[7] || st.port1_pin_config[3]))
    else $error("capture outside active scanning");
  a_capture_idx: assert property (
    capture |=>
    st.com_idx == $past(lcd_com_index) && !st.armed)
    else $error("common index not captured");
  a_seg_blank: assert property (
    st.seg_blank |-> seg_out == 32'h00000000)
    else $error("segments not blanked");
  a_t2_clk_pin: assert property (
    st.tmsel[3:2] == 2'b11 |->
    second_timer_clk_in == st.pad_q.p0[5])
    else $error("second timer clock not from pin 5");
  a_dir_reset: assert property (
    @(posedge clk) disable iff (1'b0)
    $rose(resetn) |-> st.port0_direction == 6'h00 && st.port2_direction == 2'h0)
    else $error("pins not inputs after reset");

endmodule

/* test/gksp_board.sv */
// Board model: key matrix and board signals behind the GPIO pads
`timescale 1ns/1ps

module gksp_board
  import gksp_pkg::*;
(
  input wire gksp_pkg::gksp_pads_t pad_out, // Block drive values
  input wire gksp_pkg::gksp_pads_t pad_oe, // Block drive enables
  input wire gksp_pkg::gksp_pads_t pad_pullup, // Pull-ups switched on
  input wire gksp_pkg::gksp_pads_t key_low, // Pressed keys pull low
  input wire gksp_pkg::gksp_pads_t ext, // Loose board levels
  output gksp_pkg::gksp_pads_t pad_in // Resolved pad levels
);
  // Driven pin wins; a closed key sinks an undriven pin; a key only
  // holds while pressed otherwise pull-up or board level
  always_comb begin
    for (int i = 0; i < 18; i++) begin
      if (pad_oe[i])
        pad_in[i] = pad_out[i];
      else if (key_low[i])
        pad_in[i] = 1'b0;
      else if (pad_pullup[i])
        pad_in[i] = 1'b1;
      else
        pad_in[i] = ext[i];
    end
  end
endmodule

/* test/gpio_ports_with_key_strobe_bench.sv */
// Self-checking bench for the GPIO ports and key strobe block
`timescale 1ns/1ps
`include "gksp_params.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module gpio_ports_with_key_strobe_bench;
  import gksp_pkg::*;
  logic clk = 0, resetn = 0, hsel = 0, hwrite = 0, hready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0] htrans = 0, port3_enable = 2'b11;
  logic hreadyout, hresp, lcd_on, lcd_four_com;
  gksp_pads_t pad_in, pad_out, pad_oe, pad_pullup, pad_weak;
  gksp_pads_t key_low = '0, ext = '1;
  logic [2:0] lcd_com_index = 0;
  logic lcd_com_low = 0, c1 = 0, c2 = 0, slow = 0, t1, t2, irq, hrel;
  logic [15:0] lcd_com_left = 0;
  logic [31:0] seg_data = 0, seg_out;
  logic [5:0] dr0, dt0, pu0, od0;
  logic [7:0] c0, dt3, oe3;
  logic [1:0] dr1, pu1, dr2, dt2, pu2, od2, dr3;
  logic [3:0] cf1, cf2;
  int seed = 60, check_count = 0, n_fail = 0;
  logic [9:0] rst_list [11] = '{`GKSP_IDX_PORT0_DIRECTION, `GKSP_IDX_PORT0_PIN_CONFIG,
    `GKSP_IDX_PORT1_DIRECTION, `GKSP_IDX_PORT1_PIN_CONFIG, `GKSP_IDX_PORT2_DIRECTION, `GKSP_IDX_PORT2_PIN_CONFIG,
    `GKSP_IDX_PORT3_NIBBLE_DIRECTION, `GKSP_IDX_LCD_CTL, `GKSP_IDX_KS_COM,
    `GKSP_IDX_KS_LATCH, `GKSP_IDX_IRQ_EN};

  // 40 MHz clock
  always #12.5 clk = ~clk;
  assign hready = hreadyout;

  gksp_top gksp_top_i (.clk(clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .pad_weak(pad_weak),
    .lcd_com_index(lcd_com_index), .lcd_com_low(lcd_com_low),
    .lcd_com_left(lcd_com_left), .seg_data(seg_data), .seg_out(seg_out),
    .lcd_on(lcd_on), .lcd_four_com(lcd_four_com),
    .port3_enable(port3_enable), .first_timer_carrier(c1),
    .second_timer_carrier(c2), .slow_crystal_clock(slow),
    .first_timer_clk_in(t1), .second_timer_clk_in(t2), .port0_irq(irq),
    .halt_release(hrel));
  gksp_board gksp_board_i (.pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .key_low(key_low), .ext(ext),
    .pad_in(pad_in));

  task test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Wait for ready sampled high at a rising edge, bounded
  task hi(output logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (hreadyout !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40) begin
      n_fail++;
      $display("BAD hready exp 1 got %b", hreadyout);
      test_done();
    end
    d = hrdata;
    @(posedge clk);
  endtask

  // One single-word AHB-Lite transfer; address = four times the index
  task bus(input logic w, input logic [9:0] idx, input logic [31:0] wd,
           output logic [31:0] rd);
    logic [31:0] d;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0, idx, 2'b00};
    hwrite <= w;
    hi(d);
    htrans <= 2'b00;
    hwdata <= wd;
    hi(rd);
    // Step off the edge so checks see the registers it just updated
    #1;
  endtask

  task wr(input logic [9:0] idx, input logic [31:0] wd);
    bus(1'b1, idx, wd, r);
  endtask

  task rd(input logic [9:0] idx);
    bus(1'b0, idx, 32'h0, r);
  endtask

  task press(input gksp_pads_t k);
    key_low <= k;
    repeat (4) @(posedge clk);
    key_low <= '0;
    repeat (3) @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("BAD run time exp done got hang");
    test_done();
  end

  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    foreach (rst_list[i]) begin
      rd(rst_list[i]);
      `CHK("reset reg", 32'h0, r)
    end
    `CHK("reset oe", 6'h00, pad_oe.p0)
    `CHK("lcd off", 1'b0, lcd_on)
    $display("test reset done");
    // Random directions on all ports, data on ports 0, 2 and 3, pull configuration on ports 0-2
    for (int k = 0; k < 24; k++) begin
      {dr0, dt0, c0} = {$random(seed)};
      {dr1, cf1, dr2, dt2, cf2, dr3, dt3} = {$random(seed)};
      wr(`GKSP_IDX_PORT0_PIN_CONFIG, {24'h0, c0});
      wr(`GKSP_IDX_P0_DATA, {26'h0, dt0});
      wr(`GKSP_IDX_PORT0_DIRECTION, {26'h0, dr0});
      wr(`GKSP_IDX_PORT1_PIN_CONFIG, {28'h0, cf1});
      wr(`GKSP_IDX_PORT1_DIRECTION, {30'h0, dr1});
      wr(`GKSP_IDX_PORT2_PIN_CONFIG, {28'h0, cf2});
      wr(`GKSP_IDX_P2_DATA, {30'h0, dt2});
      wr(`GKSP_IDX_PORT2_DIRECTION, {30'h0, dr2});
      wr(`GKSP_IDX_P3_DATA, {24'h0, dt3});
      wr(`GKSP_IDX_PORT3_NIBBLE_DIRECTION, {30'h0, dr3});
      ext <= gksp_pads_t'($random(seed));
      repeat (3) @(posedge clk);
      pu0 = {{2{c0[4]}}, {4{c0[0]}}} & ~dr0;
      od0 = {{2{c0[5]}}, {4{c0[1]}}};
      pu1 = {2{cf1[0]}} & ~dr1;
      pu2 = cf2[1:0] & ~dr2;
      od2 = cf2[3:2];
      oe3 = {{4{dr3[1]}}, {4{dr3[0]}}};
      `CHK("p0 pullup", pu0, pad_pullup.p0)
      `CHK("p1 pullup", pu1, pad_pullup.p1)
      `CHK("p0 oe", dr0 & ~(od0 & dt0), pad_oe.p0)
      `CHK("p0 out", dt0 & ~od0 & dr0, pad_out.p0 & dr0)
      `CHK("p2 oe", dr2 & ~(od2 & dt2), pad_oe.p2)
      `CHK("p3 oe", oe3, pad_oe.p3)
      `CHK("p3 pullup", 8'h00, pad_pullup.p3)
      `CHK("p0 weak", {{2{c0[6]}}, {4{c0[2]}}}, pad_weak.p0)
      rd(`GKSP_IDX_P0_DATA);
      `CHK("p0 read", {26'h0, dr0 | pu0 | ext.p0}, r)
      rd(`GKSP_IDX_P1_DATA);
      `CHK("p1 read", {30'h0, dr1 | pu1 | ext.p1}, r)
      rd(`GKSP_IDX_P2_DATA);
      `CHK("p2 read", {30'h0, dr2 | pu2 | ext.p2}, r)
      rd(`GKSP_IDX_P3_DATA);
      `CHK("p3 read", {24'h0, ~oe3 & ext.p3}, r)
    end
    $display("test ports done");
    // Both edges of pins 0 and 4 raise the event; pin 1 does not
    wr(`GKSP_IDX_PORT0_DIRECTION, 32'h0);
    wr(`GKSP_IDX_PORT0_PIN_CONFIG, 32'h0);
    wr(`GKSP_IDX_IRQ_EN, 32'h4);
    wr(`GKSP_IDX_HALT_RELEASE_ENABLE, 32'h4);
    for (int k = 0; k < 6; k++) begin
      wr(`GKSP_IDX_IRQ_ST, 32'h4);
      ext.p0[(k < 4) ? ((k % 2) * 4) : 1] <=
        ~ext.p0[(k < 4) ? ((k % 2) * 4) : 1];
      repeat (4) @(posedge clk);
      `CHK("p0 irq", (k < 4), irq)
      `CHK("halt rel", (k < 4), hrel)
      rd(`GKSP_IDX_IRQ_ST);
      `CHK("irq status", (k < 4) ? 32'h4 : 32'h0, r)
    end
    ext.p0[0] <= ~ext.p0[0];
    wr(`GKSP_IDX_IRQ_EN, 32'h0);
    `CHK("irq masked", 1'b0, irq)
    `CHK("halt kept", 1'b1, hrel)
    wr(`GKSP_IDX_IRQ_ST, 32'h4);
    `CHK("irq cleared", 1'b0, hrel)
    wr(`GKSP_IDX_PORT0_DIRECTION, 32'h1);
    ext.p0[0] <= ~ext.p0[0];
    repeat (4) @(posedge clk);
    `CHK("out no event", 1'b0, hrel)
    $display("test event done");
    // Key strobe: gated by LCD on, latches, holds, clears
    wr(`GKSP_IDX_PORT0_DIRECTION, 32'h0);
    wr(`GKSP_IDX_PORT0_PIN_CONFIG, 32'h09);
    ext <= '1;
    lcd_com_low <= 1'b1;
    lcd_com_left <= 16'd100;
    lcd_com_index <= 3'd3;
    press(gksp_pads_t'(18'h00002));
    rd(`GKSP_IDX_KS_LATCH);
    `CHK("latch lcd off", 32'h0, r)
    `CHK("pull lcd off", 4'hF, pad_pullup.p0[3:0])
    wr(`GKSP_IDX_KS_CTL, 32'h2);
    wr(`GKSP_IDX_LCD_CTL, 32'h80);
    `CHK("lcd on", 1'b1, lcd_on)
    `CHK("five com", 1'b0, lcd_four_com)
    lcd_com_left <= 16'd2000;
    repeat (2) @(posedge clk);
    `CHK("pull outside", 4'h0, pad_pullup.p0[3:0])
    lcd_com_left <= 16'd1200;
    repeat (2) @(posedge clk);
    `CHK("pull window", 4'hF, pad_pullup.p0[3:0])
    press(gksp_pads_t'(18'h00002));
    lcd_com_index <= 3'd1;
    press(gksp_pads_t'(18'h00004));
    rd(`GKSP_IDX_KS_LATCH);
    `CHK("latch held", 32'h02, r)
    rd(`GKSP_IDX_KS_COM);
    `CHK("com held", 32'h3, r)
    wr(`GKSP_IDX_KS_CTL, 32'h2);
    rd(`GKSP_IDX_KS_LATCH);
    `CHK("latch clear", 32'h0, r)
    wr(`GKSP_IDX_PORT0_PIN_CONFIG, 32'h0);
    wr(`GKSP_IDX_PORT1_PIN_CONFIG, 32'h09);
    lcd_com_index <= 3'd4;
    press(gksp_pads_t'(18'h00080));
    rd(`GKSP_IDX_KS_LATCH);
    `CHK("latch p1", 32'h80, r)
    rd(`GKSP_IDX_KS_COM);
    `CHK("com p1", 32'h4, r)
    $display("test strobe done");
    // Segment blanking and port 3 pads carrying segments
    seg_data <= $random(seed);
    port3_enable <= 2'b00;
    wr(`GKSP_IDX_KS_CTL, 32'h1);
    `CHK("seg blank", 32'h0, seg_out)
    wr(`GKSP_IDX_KS_CTL, 32'h0);
    `CHK("seg data", seg_data, seg_out)
    for (int i = 0; i < 8; i++)
      `CHK("seg pad", seg_data[31 - i], pad_out.p3[i])
    rd(`GKSP_IDX_KS_CTL);
    `CHK("ctl reads 0", 32'h0, r)
    // Carrier routing and timer clock selection
    wr(`GKSP_IDX_PORT1_PIN_CONFIG, 32'h0);
    wr(`GKSP_IDX_PORT1_DIRECTION, 32'h3);
    wr(`GKSP_IDX_P1_ALT, 32'h3);
    for (int k = 0; k < 4; k++) begin
      {c2, c1} <= k[1:0];
      ext.p0[5:4] <= k[1:0];
      slow <= k[0];
      wr(`GKSP_IDX_TMCLK, k[1] ? 32'h08 : 32'h0C);
      repeat (3) @(posedge clk);
      `CHK("carrier", k[1:0], pad_out.p1)
      `CHK("timer1 clk", k[0], t1)
      `CHK("timer2 clk", k[1] ? k[0] : k[1], t2)
    end
    wr(10'h3FF, 32'hFFFF_FFFF);
    rd(10'h3FF);
    `CHK("unmapped", 32'h0, r)
    `CHK("okay", 1'b0, hresp)
    $display("test misc done");
    test_done();
  end
endmodule
